// ### rtl/dpi_init_seq.sv
`timescale 1ns/1ps
// Host-side power-up, warm reset and power-off sequencer for the memory die
module dpi_init_seq
    import dpi_pkg::*;
#(
    parameter int RAMP_CYCLES    = dpi_pkg::RAMP_CYC,
    parameter int RELEASE_CYCLES = dpi_pkg::RELEASE_CYC,
    parameter int TRAIN_CYCLES   = 16,
    parameter bit DO_CBT         = 1'b1,
    parameter bit DO_WRLEV       = 1'b1,
    parameter bit DO_DQ_TRAIN    = 1'b1
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       power_good,
    input  wire logic       warm_reset_req,
    input  wire logic       power_off_req,
    input  wire logic       cal_grant,
    output logic            cal_req,
    output logic            diff_clock_true,
    output logic            diff_clock_comp,
    output logic            mem_reset_b,
    output logic            clock_gate,
    output logic            select_strobe,
    output logic [3:0]      cmd_code,
    output logic [5:0]      cmd_addr,
    output logic [7:0]      cmd_data,
    output logic            cmd_valid,
    output logic            fast_clock_ok,
    output logic            init_done,
    output logic            powered_off
);
    import dpi_pkg::*;

    dpi_state_type    state;
    logic             clk_run;
    logic             mclk;
    logic             mclk_rise;
    logic             tmr_load;
    logic [CNT_W-1:0] tmr_value;
    logic             tmr_done;
    logic [7:0]       stable_cnt;
    logic [2:0]       pg_sync;
    logic [2:0]       warm_sync;
    logic [2:0]       off_sync;
    logic [1:0]       grant_sync;
    logic             warm_edge;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = CNT_W'(n);
    endfunction

    // Asynchronous requests pass two flops before use
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pg_sync    <= 3'h0;
            warm_sync  <= 3'h0;
            off_sync   <= 3'h0;
            grant_sync <= 2'h0;
        end else begin
            pg_sync    <= {pg_sync[1:0], power_good};
            warm_sync  <= {warm_sync[1:0], warm_reset_req};
            off_sync   <= {off_sync[1:0], power_off_req};
            grant_sync <= {grant_sync[0], cal_grant};
        end
    end
    assign warm_edge = warm_sync[1] && !warm_sync[2];

    dpi_clkgen #(
        .DIV       (MCLK_DIV)
    ) dpi_clkgen_inst (
        .clk       (clk),
        .rst_b     (rst_b),
        .run       (clk_run),
        .mclk      (mclk),
        .mclk_rise (mclk_rise)
    );

    dpi_count #(
        .WIDTH (CNT_W)
    ) dpi_count_inst (
        .clk   (clk),
        .rst_b (rst_b),
        .load  (tmr_load),
        .value (tmr_value),
        .done  (tmr_done)
    );

    // Memory clock rising edges counted since the divider started, saturating at 255
    always_ff @(posedge clk) begin
        if (!rst_b || !clk_run) begin
            stable_cnt <= 8'h00;
        end else if (mclk_rise && stable_cnt != 8'hff) begin
            stable_cnt <= stable_cnt + 8'h01;
        end
    end

    // Main sequence; timer is reloaded on every state change
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= ST_RAMP_HOLD;
        end else if (off_sync[1] && state != ST_POWER_OFF) begin
            state <= ST_POWER_OFF;
        end else if (warm_edge && state != ST_POWER_OFF && state != ST_RAMP_HOLD) begin
            state <= ST_WARM_HOLD;
        end else begin
            unique case (state)
                ST_RAMP_HOLD:      if (pg_sync[1] && tmr_done) state <= ST_GATE_SETUP;
                ST_WARM_HOLD:      if (tmr_done) state <= ST_GATE_SETUP;
                ST_GATE_SETUP:     if (tmr_done) state <= ST_RELEASE_WAIT;
                ST_RELEASE_WAIT:   if (tmr_done) state <= ST_GATE_RISE;
                ST_GATE_RISE:      if (stable_cnt >= 8'(STABLE_CYC / MCLK_DIV))
                                       state <= ST_FIRST_CMD_WAIT; // see (R04)
                ST_FIRST_CMD_WAIT: if (tmr_done) state <= ST_WR_DRIVE; // see (R06)
                ST_WR_DRIVE:       state <= ST_WR_ODT;
                ST_WR_ODT:         state <= ST_CAL_GRANT; // see (R08)
                ST_CAL_GRANT:      if (grant_sync[1]) state <= ST_CAL_START; // see (R09)
                ST_CAL_START:      state <= ST_CAL_WAIT;
                ST_CAL_WAIT:       if (tmr_done) state <= ST_CAL_LATCH; // see (R10)
                ST_CAL_LATCH:      state <= ST_LATCH_QUIET;
                ST_LATCH_QUIET: begin
                    if (tmr_done) begin // see (R11)
                        // Training steps are optional per build, see (R18)
                        if (DO_CBT) begin
                            state <= ST_CBT_ON;
                        end else if (DO_WRLEV) begin
                            state <= ST_WRLEV_ON;
                        end else if (DO_DQ_TRAIN) begin
                            state <= ST_DQ_REF;
                        end else begin
                            state <= ST_READY;
                        end
                    end
                end
                ST_CBT_ON:         state <= ST_CBT_RUN; // see (R12)
                ST_CBT_RUN:        if (tmr_done) state <= ST_CBT_OFF;
                ST_CBT_OFF: begin
                    if (DO_WRLEV) begin
                        state <= ST_WRLEV_ON; // see (R14)
                    end else if (DO_DQ_TRAIN) begin
                        state <= ST_DQ_REF;
                    end else begin
                        state <= ST_READY;
                    end
                end
                ST_WRLEV_ON:       state <= ST_WRLEV_RUN;
                ST_WRLEV_RUN:      if (tmr_done) state <= ST_WRLEV_OFF;
                ST_WRLEV_OFF:      state <= DO_DQ_TRAIN ? ST_DQ_REF : ST_READY;
                ST_DQ_REF:         state <= ST_DQ_TRAIN; // see (R15)
                ST_DQ_TRAIN:       if (tmr_done) state <= ST_READY;
                ST_READY:          state <= ST_READY; // see (R17)
                ST_POWER_OFF:      if (!off_sync[1]) state <= ST_WARM_HOLD;
                default:           state <= ST_RAMP_HOLD;
            endcase
        end
    end

    // Each wait is a rounded-up cycle count, see (R21)
    always_comb begin
        tmr_value = cyc(0);
        unique case (state)
            ST_RAMP_HOLD:      tmr_value = cyc(RAMP_CYCLES);    // see (R01)
            ST_WARM_HOLD:      tmr_value = cyc(WARM_CYC);       // see (R19)
            ST_GATE_SETUP:     tmr_value = cyc(GATE_LOW_CYC);   // see (R02)
            ST_RELEASE_WAIT:   tmr_value = cyc(RELEASE_CYCLES); // see (R03)
            ST_FIRST_CMD_WAIT: tmr_value = cyc(FIRST_CMD_CYC);
            ST_CAL_WAIT:       tmr_value = cyc(IMPEDANCE_CALIBRATION_CYC);
            ST_LATCH_QUIET:    tmr_value = cyc(LATCH_CYC);
            ST_CBT_RUN, ST_WRLEV_RUN, ST_DQ_TRAIN: tmr_value = cyc(TRAIN_CYCLES);
            default:           tmr_value = cyc(0);
        endcase
    end

    // Load on entry to each timed state
    dpi_state_type prev_state;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prev_state <= ST_POWER_OFF;
        end else begin
            prev_state <= state;
        end
    end
    // Ramp wait starts only once supply good is seen, see (R01)
    assign tmr_load = (prev_state != state) || (state == ST_RAMP_HOLD && !pg_sync[1]);

    // Pin drive
    assign clk_run = state != ST_RAMP_HOLD && state != ST_WARM_HOLD && state != ST_POWER_OFF;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mem_reset_b <= 1'b0;
            clock_gate  <= 1'b0;
        end else begin
            // Reset released only after the gate-low setup elapsed, see (R02)
            mem_reset_b <= !(state == ST_RAMP_HOLD || state == ST_WARM_HOLD
                             || state == ST_GATE_SETUP || state == ST_POWER_OFF);
            // Gate held low through power-off, see (R20)
            clock_gate  <= !(state == ST_RAMP_HOLD || state == ST_WARM_HOLD
                             || state == ST_GATE_SETUP || state == ST_RELEASE_WAIT
                             || state == ST_GATE_RISE || state == ST_POWER_OFF);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cmd_valid <= 1'b0;
            cmd_code  <= CMD_NONE;
            cmd_addr  <= 6'h00;
            cmd_data  <= 8'h00;
            cal_req   <= 1'b0;
        end else begin
            cmd_valid <= 1'b1;
            cmd_addr  <= 6'h00;
            cmd_data  <= 8'h00;
            // Serialise shared-resistor calibration, see (R09)
            cal_req   <= state == ST_CAL_GRANT || state == ST_CAL_START
                         || state == ST_CAL_WAIT || state == ST_CAL_LATCH;
            unique case (state)
                ST_WR_DRIVE:  begin cmd_code <= CMD_MRW; cmd_addr <= MR_DRIVE; end
                ST_WR_ODT:    begin cmd_code <= CMD_MRW; cmd_addr <= MR_ODT; end
                ST_CAL_START: cmd_code <= CMD_ZQ_START;
                ST_CAL_LATCH: cmd_code <= CMD_ZQ_LATCH;
                ST_CBT_ON:    begin cmd_code <= CMD_MRW; cmd_addr <= MR_CBT;
                              cmd_data <= MR_CBT_ON; end
                ST_CBT_OFF:   begin cmd_code <= CMD_MRW; cmd_addr <= MR_CBT;
                              cmd_data <= MR_CBT_OFF; end
                ST_WRLEV_ON:  begin cmd_code <= CMD_MRW; cmd_addr <= MR_TWO;
                              cmd_data <= 8'(1 << MR2_WRLEV_BIT); end // see (R14)
                ST_WRLEV_OFF: begin cmd_code <= CMD_MRW; cmd_addr <= MR_TWO; end
                ST_DQ_REF:    begin cmd_code <= CMD_MRW; cmd_addr <= MR_DQ_REF; end
                ST_DQ_TRAIN:  begin cmd_code <= CMD_MPC; cmd_data <= MPC_RD_CAL; end
                default: begin
                    cmd_code  <= CMD_NONE;
                    cmd_valid <= 1'b0;
                end
            endcase
        end
    end

    // Select strobe only pulses with a command; low while gate rises, see (R05)
    assign select_strobe   = cmd_valid;
    assign diff_clock_true = mclk;
    assign diff_clock_comp = clk_run ? !mclk : 1'b0;
    // Boot clock period fixed by divider; fast clock allowed only after training, see (R07)
    assign fast_clock_ok   = state == ST_READY && MCLK_PERIOD_NS >= BOOT_CLOCK_PERIOD_NS;
    assign init_done       = state == ST_READY;
    assign powered_off     = state == ST_POWER_OFF;
endmodule

// ### include/dpi_pkg.sv
// Package of timing constants and command codes for the memory init sequencer
// Function
// (R01) Hold chip reset low at least 200 us after supply ramp completes.
// (R02) Drive clock gate low at least 10 ns before releasing chip reset.
// (R03) Keep clock gate low at least 2 ms after reset release.
// (R04) Run command clock stably at least 5 cycles before raising clock gate.
// (R05) Hold select strobe low while raising clock gate.
// (R06) Wait at least 2 us after clock gate high before mode register access.
// (R07) Pre-training mode register accesses use boot clock period of 18 ns or longer.
// (R08) Write drive and termination settings before issuing calibration start.
// (R09) Devices sharing one calibration resistor calibrate strictly one after another.
// (R10) Wait at least 1 us after calibration start, then issue latch.
// (R11) After latch stay quiet for larger of 30 ns and 8 clocks.
// (R12) Command bus training, entered by mode register write, precedes fast clocking.
// (R13) Memory returns command training results on data bus, unstrobed.
// (R14) Write leveling follows, enabled by mode register two bit 7.
// (R15) Data bus training follows write leveling, still at boot clock.
// (R16) Read calibration with internal FIFO commands leaves array contents intact.
// (R17) After training, memory accepts any command; write remaining mode registers. The sequencer idles in ST_READY and writes none.
// (R18) Training steps after latch are optional and their order may vary.
// (R19) Warm reset: hold reset at least 100 ns, gate low 10 ns before.
// (R20) Controlled power-off holds clock gate low; memory outputs stay high impedance.
// (R21) Derive each minimum wait from own-clock counters rounded up.
package dpi_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int RAMP_TO_RELEASE_WAIT_US = 200;
    localparam int GATE_LOW_BEFORE_RELEASE_NS = 10;
    localparam int RELEASE_TO_GATE_WAIT_MS = 2;
    localparam int STABLE_CLOCK_WAIT_TCK = 5;
    localparam int GATE_TO_FIRST_CMD_WAIT_US = 2;
    localparam int IMPEDANCE_CAL_TIME_US = 1;
    localparam int CAL_LATCH_QUIET_TIME_NS = 30;
    localparam int CAL_LATCH_QUIET_TCK = 8;
    localparam int WARM_CLEAR_PULSE_WIDTH_NS = 100;
    localparam int BOOT_CLOCK_PERIOD_NS = 18;
    // Cycle counts, rounded up
    localparam int RAMP_CYC = (RAMP_TO_RELEASE_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GATE_LOW_CYC_RAW = (GATE_LOW_BEFORE_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GATE_LOW_CYC = GATE_LOW_CYC_RAW < 1 ? 1 : GATE_LOW_CYC_RAW;
    localparam int RELEASE_CYC = (RELEASE_TO_GATE_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
    localparam int FIRST_CMD_CYC = (GATE_TO_FIRST_CMD_WAIT_US * 1000 + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int IMPEDANCE_CALIBRATION_CYC = (IMPEDANCE_CAL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WARM_CYC_RAW = (WARM_CLEAR_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WARM_CYC = WARM_CYC_RAW < 1 ? 1 : WARM_CYC_RAW;
    // Memory clock runs at half the block clock
    localparam int MCLK_DIV = 2;
    localparam int MCLK_PERIOD_NS = CLK_PERIOD_NS * MCLK_DIV;
    localparam int LATCH_NS_CYC = (CAL_LATCH_QUIET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LATCH_TCK_CYC = CAL_LATCH_QUIET_TCK * MCLK_DIV;
    localparam int LATCH_CYC = LATCH_NS_CYC > LATCH_TCK_CYC ? LATCH_NS_CYC : LATCH_TCK_CYC;
    localparam int STABLE_CYC = STABLE_CLOCK_WAIT_TCK * MCLK_DIV;
    localparam int CNT_W = 24;

    // Command codes on the host command bus
    localparam logic [3:0] CMD_NONE     = 4'h0;
    localparam logic [3:0] CMD_MRW      = 4'h1;
    localparam logic [3:0] CMD_MRR      = 4'h2;
    localparam logic [3:0] CMD_ZQ_START = 4'h3;
    localparam logic [3:0] CMD_ZQ_LATCH = 4'h4;
    localparam logic [3:0] CMD_MPC      = 4'h5;
    // Mode register addresses and fields used by the sequence
    localparam logic [5:0] MR_DRIVE   = 6'h03;
    localparam logic [5:0] MR_ODT     = 6'h0b;
    localparam logic [5:0] MR_TWO     = 6'h02;
    localparam logic [5:0] MR_CBT     = 6'h0d;
    localparam logic [5:0] MR_DQ_REF  = 6'h0e;
    localparam int         MR2_WRLEV_BIT = 7;
    localparam logic [7:0] MR_CBT_ON  = 8'h01;
    localparam logic [7:0] MR_CBT_OFF = 8'h00;
    localparam logic [7:0] MPC_RD_CAL = 8'h43;

    typedef enum logic [4:0] {
        ST_RAMP_HOLD, ST_GATE_SETUP, ST_RELEASE_WAIT, ST_GATE_RISE, ST_FIRST_CMD_WAIT,
        ST_WR_DRIVE, ST_WR_ODT, ST_CAL_GRANT, ST_CAL_START, ST_CAL_WAIT, ST_CAL_LATCH,
        ST_LATCH_QUIET, ST_CBT_ON, ST_CBT_RUN, ST_CBT_OFF, ST_WRLEV_ON, ST_WRLEV_RUN,
        ST_WRLEV_OFF, ST_DQ_REF, ST_DQ_TRAIN, ST_READY, ST_WARM_HOLD, ST_POWER_OFF
    } dpi_state_type;
endpackage

// ### rtl/dpi_count.sv
`timescale 1ns/1ps
// Loadable down-counter that flags when a minimum wait has elapsed
module dpi_count #(
    parameter int WIDTH = 24
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] value,
    output logic                  done
);
    logic [WIDTH-1:0] count;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            count <= '0;
        end else if (load) begin
            count <= value;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    assign done = (count == '0) && !load;
endmodule

// ### rtl/dpi_clkgen.sv
`timescale 1ns/1ps
// Divider for the memory command clock with a rising-edge strobe
module dpi_clkgen #(
    parameter int DIV = 2
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic run,
    output logic      mclk,
    output logic      mclk_rise
);
    logic [7:0] phase;

    always_ff @(posedge clk) begin
        if (!rst_b || !run) begin
            phase <= 8'h00;
            mclk  <= 1'b0;
        end else if (phase == 8'(DIV / 2 - 1)) begin
            phase <= 8'h00;
            mclk  <= !mclk;
        end else begin
            phase <= phase + 8'h01;
        end
    end

    assign mclk_rise = run && !mclk && (phase == 8'(DIV / 2 - 1));
endmodule

// ### verif/dpi_init_seq_monitor.sv
// Port-level timing checker for the memory init sequencer
`timescale 1ns/1ps
module dpi_init_seq_monitor
    import dpi_pkg::*;
#(
    parameter int RAMP_CYCLES    = 20,
    parameter int RELEASE_CYCLES = 30
) (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       power_good,
    input wire logic       warm_reset_req,
    input wire logic       power_off_req,
    input wire logic       cal_grant,
    input wire logic       cal_req,
    input wire logic       diff_clock_true,
    input wire logic       diff_clock_comp,
    input wire logic       mem_reset_b,
    input wire logic       clock_gate,
    input wire logic       select_strobe,
    input wire logic [3:0] cmd_code,
    input wire logic [5:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    input wire logic       cmd_valid,
    input wire logic       fast_clock_ok,
    input wire logic       init_done,
    input wire logic       powered_off
);
    logic [23:0] lo_cnt, hi_cnt, on_cnt;
    logic [3:0]  ck_cnt;
    logic        ck_prev, cold, drv_seen, odt_seen;
    wire         cal_go = cmd_valid && cmd_code == CMD_ZQ_START;
    wire         cal_lat = cmd_valid && cmd_code == CMD_ZQ_LATCH;
    always_ff @(posedge clk) begin
        lo_cnt <= (!rst_b || mem_reset_b || !power_good) ? '0 : lo_cnt + 1'b1;
    end
    always_ff @(posedge clk) begin
        hi_cnt <= (!mem_reset_b || clock_gate) ? '0 : hi_cnt + 1'b1;
    end
    always_ff @(posedge clk) begin
        on_cnt <= !clock_gate ? '0 : on_cnt + 1'b1;
    end
    always_ff @(posedge clk) begin
        cold <= !rst_b ? 1'b1 : (mem_reset_b ? 1'b0 : cold);
    end
    // Two low samples in a row mean the memory clock has stopped
    always_ff @(posedge clk) begin
        ck_prev <= diff_clock_true;
        if (!rst_b || (!diff_clock_true && !ck_prev)) ck_cnt <= '0;
        else if (diff_clock_true && !ck_prev && ck_cnt != 4'hf) ck_cnt <= ck_cnt + 1'b1;
    end
    always_ff @(posedge clk) begin
        if (!mem_reset_b) drv_seen <= 1'b0;
        else if (cmd_valid && cmd_code == CMD_MRW && cmd_addr == MR_DRIVE) drv_seen <= 1'b1;
        if (!mem_reset_b) odt_seen <= 1'b0;
        else if (cmd_valid && cmd_code == CMD_MRW && cmd_addr == MR_ODT) odt_seen <= 1'b1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence cal_gap;
        (!cmd_valid)[*8] ##1 !cmd_valid;
    endsequence
    sequence latch_gap;
        (!cmd_valid)[*8] ##1 (!cmd_valid)[*7];
    endsequence
    ramp_hold_a: assert property ($rose(mem_reset_b) && cold |-> lo_cnt >= RAMP_CYCLES)
        else $error("memory reset released before ramp wait");
    gate_setup_a: assert property ($rose(mem_reset_b) |-> !clock_gate && !$past(clock_gate))
        else $error("clock gate not low before reset release");
    release_wait_a: assert property ($rose(clock_gate) |-> hi_cnt >= RELEASE_CYCLES)
        else $error("clock gate raised too soon after reset release");
    clock_stable_a: assert property ($rose(clock_gate) |-> ck_cnt >= STABLE_CLOCK_WAIT_TCK)
        else $error("memory clock not stable before gate rise");
    strobe_low_a: assert property ($rose(clock_gate) |-> !select_strobe)
        else $error("select strobe high at gate rise");
    first_cmd_a: assert property (cmd_valid |-> clock_gate && on_cnt >= FIRST_CMD_CYC)
        else $error("command too soon after gate rise");
    cal_order_a: assert property (cal_go |-> drv_seen && odt_seen)
        else $error("calibration start before drive and termination writes");
    cal_grant_a: assert property (cal_go |-> cal_req && $past(cal_grant, 2))
        else $error("calibration start without resistor grant");
    cal_latch_a: assert property (cal_go |=> cal_gap ##[1:100] cal_lat)
        else $error("calibration latch too early or missing");
    latch_quiet_a: assert property (cal_lat |=> latch_gap)
        else $error("command inside latch quiet time");
    warm_reset_a: assert property ($rose(warm_reset_req) && init_done |->
        ##[1:6] !mem_reset_b && !clock_gate)
        else $error("warm reset not applied");
    power_off_a: assert property (power_off_req |-> ##[1:6] powered_off && !clock_gate)
        else $error("power-off did not hold clock gate low");
endmodule

bind dpi_init_seq dpi_init_seq_monitor #(
    .RAMP_CYCLES(RAMP_CYCLES), .RELEASE_CYCLES(RELEASE_CYCLES)
) dpi_init_seq_monitor_inst (
    .clk(clk), .rst_b(rst_b), .power_good(power_good), .warm_reset_req(warm_reset_req),
    .power_off_req(power_off_req), .cal_grant(cal_grant), .cal_req(cal_req),
    .diff_clock_true(diff_clock_true), .diff_clock_comp(diff_clock_comp),
    .mem_reset_b(mem_reset_b), .clock_gate(clock_gate), .select_strobe(select_strobe),
    .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
    .fast_clock_ok(fast_clock_ok), .init_done(init_done), .powered_off(powered_off)
);

// ### verif/dpi_mem_model.sv
// Behavioural memory die seen from its command pins
`timescale 1ns/1ps
module dpi_mem_model
    import dpi_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       diff_clock_true,
    input  wire logic       mem_reset_b,
    input  wire logic       clock_gate,
    input  wire logic       cmd_valid,
    input  wire logic [3:0] cmd_code,
    input  wire logic [5:0] cmd_addr,
    input  wire logic [7:0] cmd_data,
    output logic      [7:0] dq,
    output logic            wrlev,
    output logic      [7:0] n_bad
);
    logic [7:0] mr [0:15];
    logic [7:0] last = 8'h00;
    logic [7:0] bad_cmd = 8'h00;
    logic [7:0] bad_clk = 8'h00;
    realtime    t_rise = 0;
    assign n_bad = bad_cmd + bad_clk;
    assign wrlev = mr[MR_TWO][MR2_WRLEV_BIT];
    // Floating while gated; training echo is not tied to any strobe
    assign dq = !clock_gate ? 8'hzz : (mr[MR_CBT][0] ? last : ~last);
    always @(posedge diff_clock_true) begin
        if (mem_reset_b && $realtime - t_rise < BOOT_CLOCK_PERIOD_NS) bad_clk <= bad_clk + 1;
        t_rise = $realtime;
    end
    // Read calibration and other multi-purpose commands leave the mode registers alone
    always @(posedge clk) begin
        if (!mem_reset_b) begin
            for (int i = 0; i < 16; i++) mr[i] <= 8'h00;
        end else if (cmd_valid) begin
            if (!clock_gate) bad_cmd <= bad_cmd + 1;
            if (cmd_code == CMD_MRW) mr[cmd_addr[3:0]] <= cmd_data;
            last <= {cmd_addr, cmd_code[1:0]};
        end
    end
endmodule

// ### verif/test_dpi_init_seq.sv
// Self-checking bench for the memory init sequencer
`timescale 1ns/1ps
module test_dpi_init_seq;
    import dpi_pkg::*;
    localparam logic [17:0] EXP [10] = '{{CMD_MRW, MR_DRIVE, 8'h00}, {CMD_MRW, MR_ODT, 8'h00},
        {CMD_ZQ_START, 6'h00, 8'h00}, {CMD_ZQ_LATCH, 6'h00, 8'h00}, {CMD_MRW, MR_CBT, MR_CBT_ON},
        {CMD_MRW, MR_CBT, MR_CBT_OFF}, {CMD_MRW, MR_TWO, 8'h01 << MR2_WRLEV_BIT},
        {CMD_MRW, MR_TWO, 8'h00}, {CMD_MRW, MR_DQ_REF, 8'h00}, {CMD_MPC, 6'h00, MPC_RD_CAL}};
    localparam logic [17:0] MASK [10] = '{18'h3_ff00, 18'h3_ff00, 18'h3_c000, 18'h3_c000,
        18'h3_ffff, 18'h3_ffff, 18'h3_ffff, 18'h3_ffff, 18'h3_ff00, 18'h3_c0ff};
    localparam int          N_TRAIN = 16;
    logic        clk = 0, rst_b = 0, power_good = 0, warm_reset_req = 0;
    logic        power_off_req = 0, cal_grant = 0;
    wire         cal_req, ck_t, ck_c, mem_reset_b, clock_gate, select_strobe, cmd_valid;
    wire         fast_clock_ok, init_done, powered_off, wrlev;
    wire   [3:0] cmd_code;
    wire   [5:0] cmd_addr;
    wire   [7:0] cmd_data, dq, n_bad;
    logic [17:0] log_q [0:63];
    int          n_cmd = 0, cycles = 0, n_mismatch = 0, n_compared = 0;
    dpi_init_seq #(.RAMP_CYCLES(20), .RELEASE_CYCLES(30), .TRAIN_CYCLES(N_TRAIN))
        dpi_init_seq_inst (
        .clk(clk), .rst_b(rst_b), .power_good(power_good), .warm_reset_req(warm_reset_req),
        .power_off_req(power_off_req), .cal_grant(cal_grant), .cal_req(cal_req),
        .diff_clock_true(ck_t), .diff_clock_comp(ck_c), .mem_reset_b(mem_reset_b),
        .clock_gate(clock_gate), .select_strobe(select_strobe), .cmd_code(cmd_code),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
        .fast_clock_ok(fast_clock_ok), .init_done(init_done), .powered_off(powered_off));
    dpi_mem_model dpi_mem_model_inst (.clk(clk), .diff_clock_true(ck_t),
        .mem_reset_b(mem_reset_b), .clock_gate(clock_gate), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .dq(dq),
        .wrlev(wrlev), .n_bad(n_bad));
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (cmd_valid === 1'b1) log_q[n_cmd % 64] <= {cmd_code, cmd_addr, cmd_data};
        if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
        cycles <= cycles + 1;
        // Whole run needs well under a thousand cycles
        if (cycles == 20000) n_mismatch = n_mismatch + 1;
        if (cycles == 20000) complete_run();
    end
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_init(input int base);
        for (int i = 0; i < 3000 && init_done !== 1'b1; i++) @(negedge clk);
        repeat (2) @(negedge clk);
        check({init_done, fast_clock_ok, cal_req, wrlev, n_bad}, 18'h0_0c00);
        check(ck_t ^ ck_c, 18'h0_0001);
        // Read calibration repeats on every cycle of the training window
        check(n_cmd - base, 18'(11 + N_TRAIN));
        for (int i = 0; i < 10; i++) check(log_q[(base + i) % 64] & MASK[i], EXP[i]);
    endtask
    task automatic t_power_up();
        int base;
        base = n_cmd;
        check({10'h000, dq}, {10'h000, 8'hzz});
        repeat (5) @(negedge clk);
        power_good = 1;
        for (int i = 0; i < 2000 && cal_req !== 1'b1; i++) @(negedge clk);
        check(cal_req, 18'h0_0001);
        // Arbiter holds the shared resistor for a while
        repeat (20) @(negedge clk);
        check(n_cmd - base, 18'd2);
        cal_grant = 1;
        finish_init(base);
    endtask
    task automatic t_warm();
        int base;
        base = n_cmd;
        warm_reset_req = 1;
        for (int i = 0; i < 20 && mem_reset_b !== 1'b0; i++) @(negedge clk);
        check({mem_reset_b, clock_gate}, 18'h0);
        warm_reset_req = 0;
        finish_init(base);
    endtask
    task automatic t_power_off();
        int base;
        base = n_cmd;
        power_off_req = 1;
        repeat (8) @(negedge clk);
        check({powered_off, clock_gate, init_done, dq}, {3'b100, 8'hzz});
        power_off_req = 0;
        finish_init(base);
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1;
        t_power_up();
        t_warm();
        t_power_off();
        complete_run();
    end
endmodule
